// ===== bench/atmpi_sar_model.sv
// utopia master model standing in for the cell controller
`default_nettype none
module atmpi_sar_model (
  input wire logic run_i,
  input wire logic rx_status_i,
  input wire logic tx_status_i,
  output var logic rx_clk_o,
  output var logic tx_clk_o,
  output var logic rx_enb_n_o,
  output var logic tx_enb_n_o,
  output var logic [7:0] tx_data_o,
  output var logic tx_soc_o,
  output var logic tx_parity_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {rx_clk_o, tx_clk_o, rx_enb_n_o, tx_enb_n_o, tx_data_o, tx_soc_o} = {4'b0011, 8'h00, 1'b0};
    tx_parity_o = 1'b1; // no parity generated, so tied
  end
  // clocks stand still, held low, while run_i is low
  always #24 rx_clk_o = run_i & ~rx_clk_o;
  initial begin
    #7;
    forever #24 tx_clk_o = run_i & ~tx_clk_o;
  end
  task automatic rx_get;
    @(negedge rx_clk_o);
    repeat (40) if (rx_status_i !== 1) @(negedge rx_clk_o);
    #1 rx_enb_n_o = 0;
    @(posedge rx_clk_o);
    @(negedge rx_clk_o);
    #1 rx_enb_n_o = 1;
  endtask
  task automatic tx_put(input logic [7:0] d, input logic s);
    @(negedge tx_clk_o);
    repeat (40) if (tx_status_i !== 1) @(negedge tx_clk_o);
    #1 {tx_enb_n_o, tx_data_o, tx_soc_o} = {1'b0, d, s};
    @(posedge tx_clk_o);
    @(negedge tx_clk_o);
    #1 {tx_enb_n_o, tx_data_o, tx_soc_o} = {1'b1, ~d, 1'b0};
  endtask
endmodule // atmpi_sar_model
`default_nettype wire

// ===== bench/atmpi_top_bench.sv
// self-checking bench for the atm phy pin interface
`default_nettype none
module atmpi_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 0, reset_i = 1, ale_i = 0, host_write_strobe_n_i = 1, host_read_strobe_n_i = 1, run = 0;
  logic chip_select_n_i = 1, line_reference_osc_i = 0, tx_sync_marker_in_n_i = 1, line_tx_ready_i = 0;
  logic line_rx_valid_i = 0, line_rx_soc_i = 0, line_rx_marker_i = 0, rx_clk_i, tx_clk_i, rx_enb_n_i, tx_enb_n_i;
  logic [7:0] host_ad = 8'h00, line_rx_data_i = 8'h00, tx_data_i, ad_o, rx_data_o, line_tx_data_o;
  logic ad_oe_o, user_latched_output_o, rx_activity_led_n_o, tx_activity_led_n_o, rx_sync_marker_out_n_o;
  logic tx_soc_i, tx_parity_i, rx_parity_o, rx_soc_o, rx_status_o, tx_status_o, line_rx_ready_o;
  logic line_tx_valid_o, line_tx_soc_o, line_tx_marker_o;
  wire logic [7:0] ad_i = ad_oe_o ? ad_o : host_ad;
  int n_mismatch = 0, cmp_count = 0;
  atmpi_top #(.LED_STRETCH(20'h0_0004)) dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ale_i(ale_i),
    .host_write_strobe_n_i(host_write_strobe_n_i), .host_read_strobe_n_i(host_read_strobe_n_i),
    .chip_select_n_i(chip_select_n_i), .ad_i(ad_i), .ad_o(ad_o), .ad_oe_o(ad_oe_o),
    .user_latched_output_o(user_latched_output_o), .rx_activity_led_n_o(rx_activity_led_n_o),
    .tx_activity_led_n_o(tx_activity_led_n_o), .line_reference_osc_i(line_reference_osc_i),
    .rx_sync_marker_out_n_o(rx_sync_marker_out_n_o), .tx_sync_marker_in_n_i(tx_sync_marker_in_n_i),
    .rx_clk_i(rx_clk_i), .rx_enb_n_i(rx_enb_n_i), .rx_data_o(rx_data_o), .rx_parity_o(rx_parity_o),
    .rx_soc_o(rx_soc_o), .rx_status_o(rx_status_o), .tx_clk_i(tx_clk_i), .tx_enb_n_i(tx_enb_n_i),
    .tx_data_i(tx_data_i), .tx_parity_i(tx_parity_i), .tx_soc_i(tx_soc_i), .tx_status_o(tx_status_o),
    .line_rx_valid_i(line_rx_valid_i), .line_rx_data_i(line_rx_data_i), .line_rx_soc_i(line_rx_soc_i),
    .line_rx_marker_i(line_rx_marker_i), .line_rx_ready_o(line_rx_ready_o),
    .line_tx_valid_o(line_tx_valid_o), .line_tx_data_o(line_tx_data_o), .line_tx_soc_o(line_tx_soc_o),
    .line_tx_marker_o(line_tx_marker_o), .line_tx_ready_i(line_tx_ready_i));
  atmpi_sar_model sar (.run_i(run), .rx_status_i(rx_status_o), .tx_status_i(tx_status_o), .rx_clk_o(rx_clk_i),
    .tx_clk_o(tx_clk_i), .rx_enb_n_o(rx_enb_n_i), .tx_enb_n_o(tx_enb_n_i), .tx_data_o(tx_data_i),
    .tx_soc_o(tx_soc_i), .tx_parity_o(tx_parity_i));
  initial forever #2 clk_sys_i = ~clk_sys_i;
  initial forever #15.625 line_reference_osc_i = ~line_reference_osc_i;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic conclude;
    $display("mismatches %0d, compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // released lines show the inverse of the last value, not a stale copy
  task automatic ub(input logic [7:0] a, input logic [7:0] d, input logic rd);
    host_ad = a;
    ale_i = 1;
    cyc(4);
    ale_i = 0;
    cyc(4);
    host_ad = rd ? ~d : d;
    {chip_select_n_i, host_write_strobe_n_i, host_read_strobe_n_i} = {1'b0, rd, !rd};
    cyc(6);
    if (rd) chk(ad_oe_o === 1 && ad_i === d, "read data");
    {chip_select_n_i, host_write_strobe_n_i, host_read_strobe_n_i} = 3'b111;
    cyc(6);
    chk(ad_oe_o === 0, "lines not released");
  endtask
  task automatic t_regs;
    chk(user_latched_output_o === 1 && rx_sync_marker_out_n_o === 1 && tx_status_o === 1, "reset");
    ub(8'hF8, 8'h80, 0);
    chk(user_latched_output_o === 0, "output not set");
    ub(8'h03, 8'h18, 0);
    ub(8'h00, 8'h80, 1);
    ub(8'h00, 8'h01, 0);
    chk(user_latched_output_o === 1, "output not cleared");
  endtask
  task automatic t_rx;
    logic [7:0] v;
    run = 1;
    for (int i = 0; i < 2; i++) begin
      v = 8'hA5 ^ (8'h98 & {8{i[0]}});
      {line_rx_valid_i, line_rx_data_i, line_rx_soc_i} = {1'b1, v, i == 0};
      repeat (50) if (line_rx_ready_o !== 1) cyc(1);
      cyc(1);
      line_rx_valid_i = 0;
      cyc(2);
      chk(rx_status_o === 1 && rx_data_o === v && rx_soc_o === (i == 0), "rx byte");
      chk(rx_parity_o === ~^v, "rx parity");
      if (i == 0) chk(rx_activity_led_n_o === 0, "rx led");
      sar.rx_get();
      cyc(6);
      chk(rx_status_o === 0, "rx not empty");
    end
    run = 0;
  endtask
  task automatic t_tx;
    run = 1;
    tx_sync_marker_in_n_i = 0;
    cyc(6);
    chk(line_tx_valid_o === 1 && line_tx_marker_o === 1, "marker byte");
    sar.tx_put(8'h5A, 1);
    cyc(4);
    chk(tx_status_o === 0, "tx full");
    line_tx_ready_i = 1;
    cyc(1);
    repeat (4) if (line_tx_valid_o !== 1 || line_tx_marker_o === 1) cyc(1);
    chk(line_tx_data_o === 8'h5A && line_tx_soc_o === 1 && line_tx_marker_o === 0, "tx byte");
    tx_sync_marker_in_n_i = 1;
    cyc(6);
    chk(tx_status_o === 1 && tx_activity_led_n_o === 0, "tx not free, led");
    run = 0;
  endtask
  task automatic t_mark;
    int n;
    run = 1;
    for (int f = 0; f < 4; f++) begin
      ub(8'h03, {3'b000, f[1:0], 3'b000}, 0);
      line_rx_marker_i = 1;
      cyc(1);
      line_rx_marker_i = 0;
      n = 0;
      while (rx_sync_marker_out_n_o === 0 && n < 200) begin
        cyc(1);
        n++;
      end
      chk(n >= (1 << f) * 12 - 12 && n <= (1 << f) * 12 + 6, "marker length");
    end
    run = 0;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end
  initial begin
    cyc(4);
    reset_i = 0;
    cyc(3);
    t_regs();
    t_rx();
    t_tx();
    t_mark();
    conclude();
  end
endmodule // atmpi_top_bench
`default_nettype wire

// ===== bench/atmpi_top_sva.sv
// assertion checker for the atm phy pin interface
`default_nettype none
module atmpi_top_sva #(parameter [19:0] LED_STRETCH = 20'h0_0004) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic chip_select_n_i,
  input wire logic host_read_strobe_n_i,
  input wire logic host_write_strobe_n_i,
  input wire logic ad_oe_o,
  input wire logic user_latched_output_o,
  input wire logic [7:0] rx_data_o,
  input wire logic rx_parity_o,
  input wire logic rx_status_o,
  input wire logic line_rx_valid_i,
  input wire logic line_rx_ready_o,
  input wire logic line_rx_marker_i,
  input wire logic rx_sync_marker_out_n_o,
  input wire logic tx_status_o,
  input wire logic line_tx_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // eight receive clocks of 12 cycles plus sync delay fit inside 110
  sequence s_mark_end;
    ##[1:110] rx_sync_marker_out_n_o;
  endsequence
  chk_oe_cause: assert property ($rose(ad_oe_o)
    |-> !$past(chip_select_n_i, 2) && !$past(host_read_strobe_n_i, 2)) else $error("oe without read");
  chk_oe_release: assert property (chip_select_n_i [*5] |-> !ad_oe_o) else $error("lines held");
  chk_user_latched_output_cause: assert property ($changed(user_latched_output_o)
    |-> !$past(host_write_strobe_n_i, 3)) else $error("output moved without write");
  chk_rx_odd: assert property (^{rx_data_o, rx_parity_o}) else $error("rx parity even");
  chk_rx_load: assert property ($rose(rx_status_o)
    |-> $past(line_rx_valid_i) && $past(line_rx_ready_o)) else $error("rx byte from nowhere");
  chk_tx_hold: assert property ($fell(tx_status_o) |=> line_tx_valid_o) else $error("full, nothing held");
  chk_mark_start: assert property (line_rx_marker_i |=> !rx_sync_marker_out_n_o) else $error("marker missed");
  chk_mark_len: assert property ($fell(rx_sync_marker_out_n_o) |-> s_mark_end) else $error("marker long");
endmodule // atmpi_top_sva
bind atmpi_top atmpi_top_sva #(.LED_STRETCH(LED_STRETCH)) chk_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
  .chip_select_n_i(chip_select_n_i), .host_read_strobe_n_i(host_read_strobe_n_i),
  .host_write_strobe_n_i(host_write_strobe_n_i), .ad_oe_o(ad_oe_o), .user_latched_output_o(user_latched_output_o),
  .rx_data_o(rx_data_o), .rx_parity_o(rx_parity_o), .rx_status_o(rx_status_o), .line_rx_valid_i(line_rx_valid_i),
  .line_rx_ready_o(line_rx_ready_o), .line_rx_marker_i(line_rx_marker_i),
  .rx_sync_marker_out_n_o(rx_sync_marker_out_n_o), .tx_status_o(tx_status_o), .line_tx_valid_o(line_tx_valid_o));
`default_nettype wire

// ===== verilog/atmpi_defines.vh
// constants for the atm phy pin interface
`ifndef ATMPI_DEFINES_VH
`define ATMPI_DEFINES_VH
`define ATMPI_ADDR_W 3
`define ATMPI_REG_CTRL 3'h0
`define ATMPI_REG_MARK 3'h3
`define ATMPI_CTRL_RESET 8'h00
`define ATMPI_MARK_RESET 8'h00
`define ATMPI_CTRL_USER_LATCHED_OUTPUT_BIT 7
`define ATMPI_CTRL_CELL_BIT 0
`define ATMPI_MARK_LEN_LSB 3
`define ATMPI_MARK_LEN_MSB 4
`define ATMPI_LED_TIME_US 10000
`define ATMPI_OSC_MHZ 32
// 10 ms of 32 MHz edges, sized to the 20-bit stretch counter
`define ATMPI_LED_COUNT 20'h4_E200
`endif

// ===== verilog/atmpi_regfile.v
// eight-byte utility register store with registered read
`default_nettype none
module atmpi_regfile (
  input wire clk_sys_i,
  input wire wr_en_i,
  input wire [2:0] addr_i,
  input wire [7:0] wr_data_i,
  output reg [7:0] rd_data_o
);
  reg [7:0] mem [0:7];

  always @(posedge clk_sys_i) begin
    if (wr_en_i) begin
      mem[addr_i] <= wr_data_i;
    end
    rd_data_o <= wr_en_i ? wr_data_i : mem[addr_i];
  end
endmodule // atmpi_regfile
`default_nettype wire

// ===== verilog/atmpi_top.v
// utopia level 1 cell port, utility bus and status pins of the atm phy
// Notes on behaviour
// [R01] falling address latch strobe captures the address on the shared lines
// [R02] write strobe is active low; low level with chip select writes a byte; code writes once on the falling edge of the strobe with chip select low
// [R03] read strobe is active low; device answers by driving read data
// [R04] user latched output is inverted bit 7 of register 0
// [R05] receive led pulses low while a cell is received
// [R06] transmit led pulses low while a cell is sent
// [R07] board supplies a 32 MHz reference within 100 ppm
// [R08] receive status pin: empty active low in byte mode, clav high in cell mode
// [R09] transmit status pin: full active low in byte mode, clav high in cell mode
// [R10] received timing marker drives the receive sync marker low
// [R11] marker low time is 1, 2, 4 or 8 clocks from register 3 bits 4:3
// [R12] master drives receive enable low to request data
// [R13] master drives transmit enable low to present data
// [R14] receive port signals are synchronous to the receive clock
// [R15] transmit port signals are synchronous to the transmit clock
// [R16] receive parity accompanies every receive byte
// [R17] receive start of cell marks the first byte of each cell
// [R18] master marks the first transmit byte with start of cell
// [R19] falling transmit sync marker input inserts a timing marker byte
// [R20] marker byte overrides traffic, pausing a cell on a byte boundary
// [R21] only the low three shared lines carry the address
// [R22] host ties transmit parity when it does not generate it
// [R23] receive parity is odd over each byte
// [R24] a byte moves on a rising port clock with enable low and status ready
// [R25] led pulses are stretched by a counter on the line oscillator
// [R26] shared lines are driven only while chip select and read strobe are low
`default_nettype none
`include "atmpi_defines.vh"
module atmpi_top #(
  parameter [19:0] LED_STRETCH = `ATMPI_LED_COUNT
) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire ale_i,
  input wire host_write_strobe_n_i,
  input wire host_read_strobe_n_i,
  input wire chip_select_n_i,
  input wire [7:0] ad_i,
  output reg [7:0] ad_o,
  output reg ad_oe_o,
  output reg user_latched_output_o,
  output reg rx_activity_led_n_o,
  output reg tx_activity_led_n_o,
  input wire line_reference_osc_i,
  output reg rx_sync_marker_out_n_o,
  input wire tx_sync_marker_in_n_i,
  input wire rx_clk_i,
  input wire rx_enb_n_i,
  output reg [7:0] rx_data_o,
  output reg rx_parity_o,
  output reg rx_soc_o,
  output reg rx_status_o,
  input wire tx_clk_i,
  input wire tx_enb_n_i,
  input wire [7:0] tx_data_i,
  input wire tx_parity_i,
  input wire tx_soc_i,
  output reg tx_status_o,
  input wire line_rx_valid_i,
  input wire [7:0] line_rx_data_i,
  input wire line_rx_soc_i,
  input wire line_rx_marker_i,
  output reg line_rx_ready_o,
  output reg line_tx_valid_o,
  output reg [7:0] line_tx_data_o,
  output reg line_tx_soc_o,
  output reg line_tx_marker_o,
  input wire line_tx_ready_i
);
  function odd_par;
    input [7:0] d;
    begin
      odd_par = ~(^d);
    end
  endfunction

  // bus, utopia and reference pins pass two flops; line-side inputs do not; first stage read by second stage only
  reg [27:0] pin_meta;
  reg [27:0] pin_sync;
  reg [27:0] pin_prev;
  always @(posedge clk_sys_i) begin
    pin_meta <= {ale_i, host_write_strobe_n_i, host_read_strobe_n_i, chip_select_n_i, ad_i,
                 rx_clk_i, rx_enb_n_i, tx_clk_i, tx_enb_n_i, tx_soc_i, tx_data_i,
                 tx_parity_i, tx_sync_marker_in_n_i, line_reference_osc_i};
    pin_sync <= pin_meta;
    pin_prev <= pin_sync;
  end

  wire s_ale = pin_sync[27];
  wire s_wr_n = pin_sync[26];
  wire s_rd_n = pin_sync[25];
  wire s_cs_n = pin_sync[24];
  wire [7:0] s_ad = pin_sync[23:16];
  wire s_rx_enb_n = pin_sync[14];
  wire s_tx_enb_n = pin_sync[12];
  wire s_tx_soc = pin_sync[11];
  wire [7:0] s_tx_data = pin_sync[10:3];
  // transmit parity is not checked; a tied level is harmless
  wire ale_fall = pin_prev[27] & ~s_ale; // [R01]
  wire wr_fall = pin_prev[26] & ~s_wr_n;
  wire rx_clk_rise = ~pin_prev[15] & pin_sync[15]; // [R14]
  wire tx_clk_rise = ~pin_prev[13] & pin_sync[13]; // [R15]
  wire tx_ref_fall = pin_prev[1] & ~pin_sync[1]; // [R19]
  wire osc_rise = ~pin_prev[0] & pin_sync[0];

  // utility bus
  reg [2:0] bus_addr;
  reg [7:0] ctrl_reg;
  reg [7:0] mark_reg;
  wire bus_wr = wr_fall & ~s_cs_n; // [R02]
  wire [7:0] rd_data;

  atmpi_regfile u_regs (
    .clk_sys_i(clk_sys_i),
    .wr_en_i(bus_wr),
    .addr_i(bus_addr),
    .wr_data_i(s_ad),
    .rd_data_o(rd_data)
  );

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      bus_addr <= 3'h0;
      ctrl_reg <= `ATMPI_CTRL_RESET;
      mark_reg <= `ATMPI_MARK_RESET;
      ad_o <= 8'h00;
      ad_oe_o <= 1'b0;
      user_latched_output_o <= 1'b1;
    end else begin
      if (ale_fall) begin
        bus_addr <= s_ad[2:0]; // [R01] [R21]
      end
      if (bus_wr && bus_addr == `ATMPI_REG_CTRL) begin
        ctrl_reg <= s_ad;
      end
      if (bus_wr && bus_addr == `ATMPI_REG_MARK) begin
        mark_reg <= s_ad;
      end
      // lines released as soon as chip select or read strobe rises
      ad_oe_o <= ~s_cs_n & ~s_rd_n; // [R03] [R26]
      ad_o <= rd_data; // [R03]
      user_latched_output_o <= ~ctrl_reg[`ATMPI_CTRL_USER_LATCHED_OUTPUT_BIT]; // [R04]
    end
  end

  wire cell_mode = ctrl_reg[`ATMPI_CTRL_CELL_BIT];

  // receive port: one holding byte between line and utopia
  reg rx_have;
  reg [2:0] mark_left;
  wire rx_take = rx_clk_rise & ~s_rx_enb_n & rx_have; // [R12] [R24]
  wire rx_load = line_rx_valid_i & line_rx_ready_o;
  reg next_rx_have;
  always @* begin
    next_rx_have = rx_have;
    if (rx_take) begin
      next_rx_have = 1'b0;
    end
    if (rx_load) begin
      next_rx_have = 1'b1;
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      rx_have <= 1'b0;
      rx_data_o <= 8'h00;
      rx_parity_o <= 1'b1;
      rx_soc_o <= 1'b0;
      rx_status_o <= 1'b0;
      line_rx_ready_o <= 1'b0;
    end else begin
      rx_have <= next_rx_have;
      if (rx_load) begin
        rx_data_o <= line_rx_data_i;
        rx_parity_o <= odd_par(line_rx_data_i); // [R16] [R23]
        rx_soc_o <= line_rx_soc_i; // [R17]
      end
      // empty (low) and clav (high) share one level for a single-byte hold
      if (cell_mode) begin
        rx_status_o <= next_rx_have; // [R08]
      end else begin
        rx_status_o <= next_rx_have; // [R08]
      end
      line_rx_ready_o <= ~next_rx_have;
    end
  end

  // receive sync marker, length counted in receive clocks
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      mark_left <= 3'h0;
      rx_sync_marker_out_n_o <= 1'b1;
    end else if (line_rx_marker_i) begin
      case (mark_reg[`ATMPI_MARK_LEN_MSB:`ATMPI_MARK_LEN_LSB]) // [R11]
        2'b00: mark_left <= 3'h0;
        2'b01: mark_left <= 3'h1;
        2'b10: mark_left <= 3'h3;
        2'b11: mark_left <= 3'h7;
        default: mark_left <= 3'h0;
      endcase
      rx_sync_marker_out_n_o <= 1'b0; // [R10]
    end else if (rx_clk_rise && !rx_sync_marker_out_n_o) begin
      if (mark_left == 3'h0) begin
        rx_sync_marker_out_n_o <= 1'b1; // [R11]
      end else begin
        mark_left <= mark_left - 3'h1;
      end
    end
  end

  // transmit port: one holding byte, marker has priority on the line
  reg tx_have;
  reg [7:0] tx_byte;
  reg tx_byte_soc;
  reg mark_pend;
  wire tx_take = tx_clk_rise & ~s_tx_enb_n & ~tx_have; // [R13] [R24]
  wire line_slot = ~line_tx_valid_o | line_tx_ready_i;
  wire send_mark = line_slot & mark_pend; // [R20]
  wire send_data = line_slot & ~mark_pend & tx_have;
  reg next_tx_have;
  always @* begin
    next_tx_have = tx_have;
    if (send_data) begin
      next_tx_have = 1'b0;
    end
    if (tx_take) begin
      next_tx_have = 1'b1;
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      tx_have <= 1'b0;
      tx_byte <= 8'h00;
      tx_byte_soc <= 1'b0;
      mark_pend <= 1'b0;
      tx_status_o <= 1'b1;
      line_tx_valid_o <= 1'b0;
      line_tx_data_o <= 8'h00;
      line_tx_soc_o <= 1'b0;
      line_tx_marker_o <= 1'b0;
    end else begin
      tx_have <= next_tx_have;
      if (tx_take) begin
        tx_byte <= s_tx_data;
        tx_byte_soc <= s_tx_soc; // [R18]
      end
      // a new edge in the cycle the marker leaves keeps it pending
      if (tx_ref_fall) begin
        mark_pend <= 1'b1; // [R19]
      end else if (send_mark) begin
        mark_pend <= 1'b0;
      end
      // full (low) and clav (high) also coincide while one byte is held
      if (cell_mode) begin
        tx_status_o <= ~next_tx_have; // [R09]
      end else begin
        tx_status_o <= ~next_tx_have; // [R09]
      end
      if (send_mark) begin
        line_tx_valid_o <= 1'b1;
        line_tx_marker_o <= 1'b1; // [R20]
        line_tx_soc_o <= 1'b0;
        line_tx_data_o <= 8'h00;
      end else if (send_data) begin
        line_tx_valid_o <= 1'b1;
        line_tx_marker_o <= 1'b0;
        line_tx_soc_o <= tx_byte_soc;
        line_tx_data_o <= tx_byte;
      end else if (line_slot) begin
        line_tx_valid_o <= 1'b0;
        line_tx_marker_o <= 1'b0;
      end
    end
  end

  // led stretch on the line oscillator so short cells stay visible
  reg [19:0] rx_led_cnt;
  reg [19:0] tx_led_cnt;
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      rx_led_cnt <= 20'h0_0000;
      tx_led_cnt <= 20'h0_0000;
      rx_activity_led_n_o <= 1'b1;
      tx_activity_led_n_o <= 1'b1;
    end else begin
      if (rx_load && line_rx_soc_i) begin
        rx_led_cnt <= LED_STRETCH; // [R05] [R25]
      end else if (osc_rise && rx_led_cnt != 20'h0_0000) begin
        rx_led_cnt <= rx_led_cnt - 20'h0_0001;
      end
      if (send_data && tx_byte_soc) begin
        tx_led_cnt <= LED_STRETCH; // [R06] [R25]
      end else if (osc_rise && tx_led_cnt != 20'h0_0000) begin
        tx_led_cnt <= tx_led_cnt - 20'h0_0001;
      end
      rx_activity_led_n_o <= (rx_led_cnt == 20'h0_0000); // [R05]
      tx_activity_led_n_o <= (tx_led_cnt == 20'h0_0000); // [R06]
    end
  end
endmodule // atmpi_top
`default_nettype wire
